// [rtl/oric_pkg.sv]
package oric_pkg;
  // drum timing, in ns, and derived cycle counts at 100 MHz
  localparam int CLK_PERIOD_NS  = 10;
  localparam int SET_DELAY_NS   = 1200;
  localparam int RESET_DELAY_NS = 400;
  localparam int WINDOW_NS      = 5400;
  localparam int SET_DELAY_CYC  = (SET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_DELAY_CYC = (RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WINDOW_CYC     = WINDOW_NS / CLK_PERIOD_NS;
  localparam int CNT_W          = 10;

  // section address codes
  localparam logic [2:0] SEC_GG = 3'h2;
  localparam logic [2:0] SEC_TP = 3'h3;
  localparam logic [2:0] SEC_GA = 3'h5;

  // highest legal register address per section
  localparam logic [4:0] REG_MAX_GG = 5'h18;
  localparam logic [4:0] REG_MAX_GA = 5'h0b;

  // channel index within the write generator
  localparam int CH_GGA = 0;
  localparam int CH_GGB = 1;
  localparam int CH_GAA = 2;
  localparam int CH_GAB = 3;
  localparam int CH_TP  = 4;
  localparam int NUM_CH = 5;

  // register map, word addresses are byte offsets
  localparam logic [7:0] ADR_STATUS = 8'h00;
  localparam logic [7:0] ADR_CLEAR  = 8'h04;
  localparam logic [7:0] ADR_ENABLE = 8'h08;
  localparam logic [7:0] ADR_CTRL   = 8'h0c;
  localparam logic [7:0] ADR_COUNT  = 8'h10;
  localparam int EV_W = 4;
  localparam int EV_ACCEPT = 0;
  localparam int EV_MISSED = 1;
  localparam int EV_NOCMP  = 2;
  localparam int EV_ADRERR = 3;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_SETW  = 4'b0010,
    ST_HOLD  = 4'b0100,
    ST_TAIL  = 4'b1000
  } oric_state_t;
endpackage : oric_pkg

// [rtl/oric_sync.sv]
`timescale 1ns/1ns
`default_nettype none
// two-flop synchroniser for pin levels and drum pulses
module oric_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_reg <= '0;
      dout     <= '0;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end
endmodule : oric_sync
`default_nettype wire

// [rtl/oric_read_in.sv]
`timescale 1ns/1ns
`default_nettype none
// Contract
// - all read-in actions of one word finish within 5.4 us from phase 2
// - right-half word, parity and register address ready at the drivers by phase 2
// - accept only on search time, burst compare, good parity, no address error
// - readout time with all else good flags missed word, alarm, erase
// - error-free word with burst mismatch gets a no-compare pulse, kept on drum
// - compare with parity, address or missed error: no no-compare, no transfer
// - at phase 2, inhibit pulses block every channel but the selected one
// - set level 1.2 us after inhibit gates data into the uninhibited channel
// - reset level at phase 4 plus 0.4 us ends read-in of the selected section
// - three per-section parts plus one common part
// - section-2 select means ground-to-ground; its compare is that burst match
// - search allows fill; not-search means readout, no array written
// - phase-A enables read-in to array B, phase-B to array A
// - select, search, compare with phase-B give an array-A reset pulse
// - only section codes 2, 3, 5 legal; others are address errors
// - one shift pulse to the completed-message shifter per accepted ground word
module oric_read_in (
  input  wire logic        mclk,
  input  wire logic        rst,
  // drum side
  input  wire logic        drumPhase1,
  input  wire logic        drumPhase2,
  input  wire logic        drumPhase4,
  input  wire logic [2:0]  sectionAddr,
  input  wire logic [4:0]  registerAddr,
  input  wire logic [17:0] rightHalfWord,
  input  wire logic        parityGood,
  input  wire logic [2:0]  compareLvl,
  input  wire logic [2:0]  searchLvl,
  input  wire logic [2:0]  shiftPhaseA,
  input  wire logic [2:0]  shiftPhaseB,
  // storage side
  output logic [4:0]  inhibitOut,
  output logic        setLevel,
  output logic [17:0] storageDataDriver,
  output logic        storageParity,
  output logic [4:0]  storageRegAddr,
  output logic [4:0]  writeCurrentDriverReset,
  output logic        ggArrayAReset,
  output logic        ggArrayBReset,
  output logic        completedMessageShift,
  output logic        noComparePulse,
  output logic        missedWordAlarm,
  output logic        addressErrorPulse,
  // wishbone
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic        wb_ack_o,
  output logic        irq
);
  localparam int DIN_W = 3 + 5 + 18 + 1 + 3 + 3 + 3 + 3;

  // index 0 = ground-to-ground, 1 = teleprinter, 2 = ground-to-air
  function automatic logic [2:0] sec_select(input logic [2:0] code);
    sec_select = {code == oric_pkg::SEC_GA, code == oric_pkg::SEC_TP,
                  code == oric_pkg::SEC_GG};
  endfunction : sec_select

  logic [DIN_W-1:0] dinRaw;
  logic [DIN_W-1:0] dinSync;
  logic [2:0]       pulseSync;
  logic [2:0]       pulseDly;
  logic [2:0]       secS;
  logic [4:0]       regS;
  logic [17:0]      rhwS;
  logic             parS;
  logic [2:0]       cmpS;
  logic [2:0]       srchS;
  logic [2:0]       phAS;
  logic [2:0]       phBS;
  logic             ph2Edge;
  logic             ph4Edge;

  assign dinRaw = {sectionAddr, registerAddr, rightHalfWord, parityGood,
                   compareLvl, searchLvl, shiftPhaseA, shiftPhaseB};

  // drum pulses and word fields cross with two flops each
  oric_sync #(.W(DIN_W)) u_sync_data (
    .mclk (mclk),
    .rst  (rst),
    .din  (dinRaw),
    .dout (dinSync)
  );
  oric_sync #(.W(3)) u_sync_pulse (
    .mclk (mclk),
    .rst  (rst),
    .din  ({drumPhase4, drumPhase2, drumPhase1}),
    .dout (pulseSync)
  );

  assign {secS, regS, rhwS, parS, cmpS, srchS, phAS, phBS} = dinSync;

  always_ff @(posedge mclk) begin
    if (rst) pulseDly <= '0;
    else     pulseDly <= pulseSync;
  end
  assign ph2Edge = pulseSync[1] & ~pulseDly[1];
  assign ph4Edge = pulseSync[2] & ~pulseDly[2];

  // section parts: one per message class, decision combinational from levels
  logic [2:0] sel;
  logic       secErr;
  logic       regErr;
  logic       addrErr;
  logic [2:0] selSearchCmp;
  logic [2:0] selMissed;
  logic [4:0] chanAccept;
  logic       anyMissed;
  logic       selCmp;
  logic       noCmpCond;

  assign sel    = sec_select(secS);
  assign secErr = ~|sel;
  assign regErr = ((sel[0] | sel[1]) && regS > oric_pkg::REG_MAX_GG) ||
                  (sel[2] && regS > oric_pkg::REG_MAX_GA);
  assign addrErr = secErr | regErr;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sec
      assign selSearchCmp[gi] = sel[gi] & cmpS[gi] & srchS[gi];
      assign selMissed[gi]    = sel[gi] & cmpS[gi] & ~srchS[gi];
    end
  endgenerate

  // common part: only a clean word opens a channel
  logic clean;
  assign clean = parS & ~addrErr;
  // phase-A names array A as being read out, so fill goes to B
  assign chanAccept[oric_pkg::CH_GGA] = clean & selSearchCmp[0] & phBS[0];
  assign chanAccept[oric_pkg::CH_GGB] = clean & selSearchCmp[0] & phAS[0] & ~phBS[0];
  assign chanAccept[oric_pkg::CH_GAA] = clean & selSearchCmp[2] & phBS[2];
  assign chanAccept[oric_pkg::CH_GAB] = clean & selSearchCmp[2] & phAS[2] & ~phBS[2];
  assign chanAccept[oric_pkg::CH_TP]  = clean & selSearchCmp[1];
  assign anyMissed = clean & |selMissed;
  assign selCmp    = |(sel & cmpS);
  assign noCmpCond = parS & ~addrErr & |sel & ~selCmp;

  // read-in window sequencer
  oric_pkg::oric_state_t state_reg;
  logic [oric_pkg::CNT_W-1:0] cnt_reg;
  logic [4:0] chan_reg;
  logic       missed_reg;
  logic       enable_ctl_reg;

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg  <= oric_pkg::ST_IDLE;
      cnt_reg    <= '0;
      chan_reg   <= '0;
      missed_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        oric_pkg::ST_IDLE: begin
          if (ph2Edge && enable_ctl_reg) begin
            // latch the decision once so at most one channel opens
            chan_reg   <= chanAccept;
            missed_reg <= anyMissed;
            cnt_reg    <= oric_pkg::CNT_W'(oric_pkg::SET_DELAY_CYC - 1);
            state_reg  <= oric_pkg::ST_SETW;
          end
        end
        oric_pkg::ST_SETW: begin
          if (cnt_reg == '0) state_reg <= oric_pkg::ST_HOLD;
          else cnt_reg <= cnt_reg - 1'b1;
        end
        oric_pkg::ST_HOLD: begin
          if (ph4Edge) begin
            cnt_reg   <= oric_pkg::CNT_W'(oric_pkg::RESET_DELAY_CYC - 1);
            state_reg <= oric_pkg::ST_TAIL;
          end
        end
        oric_pkg::ST_TAIL: begin
          if (cnt_reg == '0) state_reg <= oric_pkg::ST_IDLE;
          else cnt_reg <= cnt_reg - 1'b1;
        end
      endcase
    end
  end

  logic tailDone;
  assign tailDone = (state_reg == oric_pkg::ST_TAIL) && (cnt_reg == '0);

  // inhibit pulses, data drivers and set level
  always_ff @(posedge mclk) begin
    if (rst) begin
      inhibitOut        <= '0;
      setLevel          <= 1'b0;
      storageDataDriver <= '0;
      storageParity     <= 1'b0;
      storageRegAddr    <= '0;
    end else begin
      inhibitOut <= (ph2Edge && enable_ctl_reg &&
                     state_reg == oric_pkg::ST_IDLE) ? ~chanAccept : '0;
      if (pulseSync[1]) begin
        storageDataDriver <= rhwS;
        storageParity     <= parS;
        storageRegAddr    <= regS;
      end
      if (state_reg == oric_pkg::ST_SETW && cnt_reg == '0 && |chan_reg) setLevel <= 1'b1;
      else if (ph4Edge) setLevel <= 1'b0;
    end
  end

  // phase-2 decision pulses, plus end-of-window write-current reset and missed-word alarm
  always_ff @(posedge mclk) begin
    if (rst) begin
      writeCurrentDriverReset <= '0;
      ggArrayAReset           <= 1'b0;
      ggArrayBReset           <= 1'b0;
      completedMessageShift   <= 1'b0;
      noComparePulse          <= 1'b0;
      missedWordAlarm         <= 1'b0;
      addressErrorPulse       <= 1'b0;
    end else begin
      writeCurrentDriverReset <= tailDone ? chan_reg : '0;
      ggArrayAReset <= ph2Edge && state_reg == oric_pkg::ST_IDLE && enable_ctl_reg &&
                       chanAccept[oric_pkg::CH_GGA];
      ggArrayBReset <= ph2Edge && state_reg == oric_pkg::ST_IDLE && enable_ctl_reg &&
                       chanAccept[oric_pkg::CH_GGB];
      completedMessageShift <= ph2Edge && state_reg == oric_pkg::ST_IDLE && enable_ctl_reg &&
                               (chanAccept[oric_pkg::CH_GGA] | chanAccept[oric_pkg::CH_GGB]);
      noComparePulse    <= ph2Edge && state_reg == oric_pkg::ST_IDLE && enable_ctl_reg &&
                           noCmpCond;
      missedWordAlarm   <= tailDone && missed_reg;
      addressErrorPulse <= ph2Edge && state_reg == oric_pkg::ST_IDLE && enable_ctl_reg &&
                           addrErr;
    end
  end

  // wishbone slave, one wait state, ack drops after one cycle
  logic [oric_pkg::EV_W-1:0] status_reg;
  logic [oric_pkg::EV_W-1:0] irqEn_reg;
  logic [15:0]               accCount_reg;
  logic [oric_pkg::EV_W-1:0] evSet;
  logic                      wbHit;
  logic                      wbWr;

  assign wbHit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wbWr  = wbHit & wb_we_i & wb_sel_i[0];
  assign evSet = {addressErrorPulse, noComparePulse, missedWordAlarm,
                  completedMessageShift | (|writeCurrentDriverReset)};

  always_ff @(posedge mclk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wbHit;
      if (wbHit && !wb_we_i) begin
        case (wb_adr_i)
          oric_pkg::ADR_STATUS: wb_dat_o <= {28'h0, status_reg};
          oric_pkg::ADR_ENABLE: wb_dat_o <= {28'h0, irqEn_reg};
          oric_pkg::ADR_CTRL:   wb_dat_o <= {31'h0, enable_ctl_reg};
          oric_pkg::ADR_COUNT:  wb_dat_o <= {16'h0, accCount_reg};
          default:              wb_dat_o <= '0;
        endcase
      end
    end
  end

  // set wins over a same-cycle clear
  always_ff @(posedge mclk) begin
    if (rst) status_reg <= '0;
    else if (wbWr && wb_adr_i == oric_pkg::ADR_CLEAR)
      status_reg <= (status_reg & ~wb_dat_i[oric_pkg::EV_W-1:0]) | evSet;
    else status_reg <= status_reg | evSet;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      irqEn_reg      <= '0;
      enable_ctl_reg <= 1'b1;
    end else if (wbWr) begin
      if (wb_adr_i == oric_pkg::ADR_ENABLE) irqEn_reg <= wb_dat_i[oric_pkg::EV_W-1:0];
      if (wb_adr_i == oric_pkg::ADR_CTRL) enable_ctl_reg <= wb_dat_i[0];
    end
  end

  // one reset pulse per accepted word, so every section is counted once
  always_ff @(posedge mclk) begin
    if (rst) accCount_reg <= '0;
    else if (|writeCurrentDriverReset)
      accCount_reg <= accCount_reg + 16'h1;
  end

  always_ff @(posedge mclk) begin
    if (rst) irq <= 1'b0;
    else     irq <= |(status_reg & irqEn_reg);
  end

  // at most one channel left uninhibited
  a_one_channel: assert property (@(posedge mclk) disable iff (rst)
    $onehot0(chan_reg)) else $error("more than one channel accepted");
  a_set_delay: assert property (@(posedge mclk) disable iff (rst)
    $rose(setLevel) |-> $past(state_reg == oric_pkg::ST_SETW))
    else $error("set level outside set wait");
  a_inhibit_sel: assert property (@(posedge mclk) disable iff (rst)
    |inhibitOut |=> ##[119:121] (setLevel || chan_reg == '0))
    else $error("set level not 1.2 us after inhibit");
  a_reset_tail: assert property (@(posedge mclk) disable iff (rst)
    ph4Edge && state_reg == oric_pkg::ST_HOLD |-> ##41 (state_reg == oric_pkg::ST_IDLE))
    else $error("reset level not at phase 4 plus 0.4 us");
  a_nocmp_block: assert property (@(posedge mclk) disable iff (rst)
    noComparePulse |-> $past(~addrErr & parS)) else $error("no-compare on bad word");
  a_missed_no_write: assert property (@(posedge mclk) disable iff (rst)
    missedWordAlarm |-> $past(chan_reg == '0)) else $error("missed word was written");
  a_shift_accept: assert property (@(posedge mclk) disable iff (rst)
    completedMessageShift |-> $past(sel[0] & cmpS[0] & srchS[0] & parS))
    else $error("shift pulse without accepted ground word");
  a_section_legal: assert property (@(posedge mclk) disable iff (rst)
    addressErrorPulse |-> chan_reg == '0)
    else $error("illegal address accepted");
endmodule : oric_read_in
`default_nettype wire

// [tb/oric_drum_model.sv]
`timescale 1ns/1ns
`default_nettype none
module oric_drum_model #(
  parameter int PH4_GAP = 500
) (
  input  wire logic        mclk,
  input  wire logic        noComparePulse,
  output logic             drumPhase1,
  output logic             drumPhase2,
  output logic             drumPhase4,
  output logic [2:0]       sectionAddr,
  output logic [4:0]       registerAddr,
  output logic [17:0]      rightHalfWord,
  output logic             parityGood,
  output logic             wordKept
);
  initial begin
    {drumPhase1, drumPhase2, drumPhase4, wordKept} = 4'h0;
    {sectionAddr, registerAddr, rightHalfWord, parityGood} = '1;
  end
  // without a no-compare the slot is reused, so the word is gone
  always @(posedge mclk) begin
    if (noComparePulse === 1'b1) begin
      wordKept <= 1'b1;
    end
  end
  task automatic sendWord(input logic [2:0] sec, input logic [4:0] ra,
                          input logic [17:0] d, input logic par);
    wordKept      <= 1'b0;
    sectionAddr   <= sec;
    registerAddr  <= ra;
    rightHalfWord <= d;
    parityGood    <= par;
    drumPhase1    <= 1'b1;
    repeat (2) @(posedge mclk);
    drumPhase1 <= 1'b0;
    repeat (40) @(posedge mclk);
    drumPhase2 <= 1'b1;
    repeat (2) @(posedge mclk);
    drumPhase2 <= 1'b0;
    repeat (PH4_GAP - 2) @(posedge mclk);
    drumPhase4 <= 1'b1;
    repeat (2) @(posedge mclk);
    drumPhase4 <= 1'b0;
    repeat (60) @(posedge mclk);
    // slot released: stale levels would hide a late read
    {sectionAddr, registerAddr, rightHalfWord, parityGood} <= ~{sec, ra, d, par};
    @(posedge mclk);
  endtask : sendWord
endmodule : oric_drum_model
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        clr = 1'b0;
  logic        ph1, ph2, ph4, parGood, kept, setLevel, stPar, noCmp, missed, adrErr;
  logic        arA, arB, shift, wbAck, irq, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
  logic [2:0]  secAddr, cmpLvl = '0, srchLvl = '0, phA = '0, phB = '0;
  logic [4:0]  regAddr, inhibit, stReg, wcdReset, inhSeen, wcdSeen, raSeen;
  logic [7:0]  wbAdr = '0;
  logic [17:0] rhw, stData, datSeen;
  logic [31:0] wbDatI = '0, wbDatO, rd;
  int          failCount = 0, nChecks = 0, cycN = 0, nAcc = 0;
  int          tInh, tSet, tFall, tWcd, nNc, nMiss, nAdr, nSh, nA, nB;

  always #5 mclk = ~mclk;

  oric_drum_model i_oric_drum_model (.mclk(mclk), .noComparePulse(noCmp),
    .drumPhase1(ph1), .drumPhase2(ph2), .drumPhase4(ph4), .sectionAddr(secAddr),
    .registerAddr(regAddr), .rightHalfWord(rhw), .parityGood(parGood), .wordKept(kept));
  oric_read_in i_oric_read_in (.mclk(mclk), .rst(rst), .drumPhase1(ph1),
    .drumPhase2(ph2), .drumPhase4(ph4), .sectionAddr(secAddr), .registerAddr(regAddr),
    .rightHalfWord(rhw), .parityGood(parGood), .compareLvl(cmpLvl), .searchLvl(srchLvl),
    .shiftPhaseA(phA), .shiftPhaseB(phB), .inhibitOut(inhibit), .setLevel(setLevel),
    .storageDataDriver(stData), .storageParity(stPar), .storageRegAddr(stReg),
    .writeCurrentDriverReset(wcdReset), .ggArrayAReset(arA), .ggArrayBReset(arB),
    .completedMessageShift(shift), .noComparePulse(noCmp), .missedWordAlarm(missed),
    .addressErrorPulse(adrErr), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(4'hf), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck), .irq(irq));

  // pulses are one cycle wide, so they are gathered here rather than polled
  always @(posedge mclk) begin
    cycN <= cycN + 1;
    if (clr) begin
      {inhSeen, wcdSeen} <= '0;
      {tSet, nNc, nMiss, nAdr, nSh, nA, nB} <= '0;
    end else begin
      if (inhibit !== 5'h00) inhSeen <= inhibit;
      if (inhibit !== 5'h00) tInh <= cycN;
      if (setLevel === 1'b1 && tSet == 0) tSet <= cycN;
      if (setLevel === 1'b1) tFall <= cycN + 1;
      if (setLevel === 1'b1) datSeen <= stData;
      if (setLevel === 1'b1) raSeen <= stReg;
      if (wcdReset !== 5'h00) wcdSeen <= wcdReset;
      if (wcdReset !== 5'h00) tWcd <= cycN;
      nNc <= nNc + int'(noCmp);
      nMiss <= nMiss + int'(missed);
      nAdr <= nAdr + int'(adrErr);
      nSh <= nSh + int'(shift);
      nA <= nA + int'(arA);
      nB <= nB + int'(arB);
    end
  end

  task automatic endSim();
    $display("checks %0d mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : endSim

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    nChecks++;
    if (g !== e) begin
      failCount++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wbXfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
    int n;
    n = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatI <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    q = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    if (n >= 50) begin
      failCount++;
      endSim();
    end
    @(posedge mclk);
  endtask : wbXfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wbXfer(1'b1, a, d, rd);
  endtask : wr

  task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] e);
    wbXfer(1'b0, a, 32'h0, rd);
    chk(nm, e, rd);
  endtask : rdChk

  task automatic runWord(input logic [2:0] sec, input logic [4:0] ra, input logic [17:0] d,
                         input logic par, input logic [2:0] c, s, pa, pb);
    cmpLvl <= c;
    srchLvl <= s;
    phA <= pa;
    phB <= pb;
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
    i_oric_drum_model.sendWord(sec, ra, d, par);
  endtask : runWord

  task automatic expAccept(input int ch, input logic [17:0] d, input logic [4:0] ra);
    logic [4:0] one;
    one = 5'h01 << ch;
    nAcc++;
    chk("inhibit", {27'h0, ~one}, {27'h0, inhSeen});
    chk("set delay", oric_pkg::SET_DELAY_CYC, tSet - tInh);
    chk("data", {14'h0, d}, {14'h0, datSeen});
    chk("reg addr", {27'h0, ra}, {27'h0, raSeen});
    chk("parity", 32'h1, {31'h0, stPar});
    chk("wcd reset", {27'h0, one}, {27'h0, wcdSeen});
    chk("reset delay", oric_pkg::RESET_DELAY_CYC, tWcd - tFall);
    chk("window", 32'h1, 32'(tWcd - tInh <= oric_pkg::WINDOW_CYC));
    chk("shift", 32'(ch <= oric_pkg::CH_GGB), nSh);
    chk("array a reset", 32'(ch == oric_pkg::CH_GGA), nA);
    chk("array b reset", 32'(ch == oric_pkg::CH_GGB), nB);
    chk("nocompare", 32'h0, nNc);
    chk("kept", 32'h0, {31'h0, kept});
  endtask : expAccept

  task automatic expReject(input int nc, input int miss, input int adr);
    chk("set", 32'h0, tSet);
    chk("inhibit all", 32'h1f, {27'h0, inhSeen});
    chk("wcd reset", 32'h0, {27'h0, wcdSeen});
    chk("nocompare", nc, nNc);
    chk("kept", nc, {31'h0, kept});
    chk("missed", miss, nMiss);
    chk("addr error", adr, nAdr);
    chk("shift", 32'h0, nSh);
  endtask : expReject

  task automatic scRegs();
    rdChk("status", oric_pkg::ADR_STATUS, 32'h0);
    rdChk("ctrl", oric_pkg::ADR_CTRL, 32'h1);
    wr(8'h20, 32'hffff_ffff);
    rdChk("unmapped", 8'h20, 32'h0);
    wr(oric_pkg::ADR_CTRL, 32'h0);
    runWord(oric_pkg::SEC_GG, 5'h01, 18'h00001, 1'b1, 3'h1, 3'h1, 3'h0, 3'h1);
    chk("disabled set", 32'h0, tSet);
    wr(oric_pkg::ADR_CTRL, 32'h1);
  endtask : scRegs

  task automatic scGround();
    runWord(oric_pkg::SEC_GG, 5'h18, 18'h2a5c3, 1'b1, 3'h1, 3'h1, 3'h0, 3'h1);
    expAccept(oric_pkg::CH_GGA, 18'h2a5c3, 5'h18);
    runWord(oric_pkg::SEC_GG, 5'h00, 18'h15a3c, 1'b1, 3'h1, 3'h1, 3'h1, 3'h0);
    expAccept(oric_pkg::CH_GGB, 18'h15a3c, 5'h00);
  endtask : scGround

  task automatic scOthers();
    runWord(oric_pkg::SEC_TP, 5'h18, 18'h3ffff, 1'b1, 3'h2, 3'h2, 3'h0, 3'h0);
    expAccept(oric_pkg::CH_TP, 18'h3ffff, 5'h18);
    runWord(oric_pkg::SEC_GA, 5'h0b, 18'h00f0f, 1'b1, 3'h4, 3'h4, 3'h4, 3'h0);
    expAccept(oric_pkg::CH_GAB, 18'h00f0f, 5'h0b);
    runWord(oric_pkg::SEC_GA, 5'h03, 18'h30303, 1'b1, 3'h4, 3'h4, 3'h0, 3'h4);
    expAccept(oric_pkg::CH_GAA, 18'h30303, 5'h03);
  endtask : scOthers

  task automatic scRejects();
    runWord(oric_pkg::SEC_GG, 5'h02, 18'h11111, 1'b1, 3'h1, 3'h0, 3'h0, 3'h1);
    expReject(0, 1, 0);
    runWord(oric_pkg::SEC_GG, 5'h02, 18'h22222, 1'b1, 3'h6, 3'h7, 3'h0, 3'h1);
    expReject(1, 0, 0);
    runWord(oric_pkg::SEC_GG, 5'h02, 18'h33333, 1'b0, 3'h1, 3'h1, 3'h0, 3'h1);
    expReject(0, 0, 0);
    chk("parity", 32'h0, {31'h0, stPar});
    runWord(3'h1, 5'h02, 18'h04444, 1'b1, 3'h7, 3'h7, 3'h0, 3'h7);
    expReject(0, 0, 1);
    runWord(oric_pkg::SEC_GA, 5'h0c, 18'h05555, 1'b1, 3'h4, 3'h4, 3'h0, 3'h4);
    expReject(0, 0, 1);
    runWord(oric_pkg::SEC_GG, 5'h19, 18'h06666, 1'b1, 3'h1, 3'h1, 3'h0, 3'h1);
    expReject(0, 0, 1);
    runWord(oric_pkg::SEC_TP, 5'h19, 18'h07777, 1'b1, 3'h2, 3'h2, 3'h0, 3'h0);
    expReject(0, 0, 1);
  endtask : scRejects

  task automatic scIrq();
    wr(oric_pkg::ADR_CLEAR, 32'hf);
    rdChk("status clear", oric_pkg::ADR_STATUS, 32'h0);
    wr(oric_pkg::ADR_ENABLE, 32'h1 << oric_pkg::EV_NOCMP);
    rdChk("irq enable", oric_pkg::ADR_ENABLE, 32'h1 << oric_pkg::EV_NOCMP);
    runWord(oric_pkg::SEC_TP, 5'h04, 18'h0abcd, 1'b1, 3'h0, 3'h2, 3'h0, 3'h0);
    chk("irq raised", 32'h1, {31'h0, irq});
    rdChk("status", oric_pkg::ADR_STATUS, 32'h1 << oric_pkg::EV_NOCMP);
    wr(oric_pkg::ADR_CLEAR, 32'h1 << oric_pkg::EV_NOCMP);
    @(posedge mclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rdChk("count", oric_pkg::ADR_COUNT, nAcc);
  endtask : scIrq

  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk("irq reset", 32'h0, {31'h0, irq});
    scRegs();
    scGround();
    scOthers();
    scRejects();
    scIrq();
    endSim();
  end
endmodule : tb_top
`default_nettype wire
